// ---- csa_bus_req_model.sv ----
`timescale 1ns/1ps
// External requester: asks for the bus, keeps it a few cycles once granted, then lets go
module csa_bus_req_model #(
  parameter int HOLD = 4
) (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic grant,
  output logic      req
);
  int cnt = 0;

  initial req = 1'b0;

  // Request stays up until served; dropping it early would abort the handover
  always @(posedge clk) begin
    if (go) begin
      req <= 1'b1;
    end else if (req && grant) begin
      cnt <= cnt + 1;
      if (cnt == HOLD) begin
        req <= 1'b0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule // csa_bus_req_model

// ---- csa_check_sva.sv ----
`timescale 1ns/1ps
// Watches the core state and access-check ports
module csa_check
  import csa_pkg::*;
(
  input wire logic         SYS_CLK,
  input wire logic         RST,
  input wire csa_acc_req_t ACC_REQ,
  input wire csa_acc_rsp_t ACC_RSP,
  input wire logic         FETCH_VALID,
  input wire logic [31:0]  FETCH_PC,
  input wire logic [2:0]   CPU_STATE,
  input wire logic [31:0]  STATUS_WORD,
  input wire logic         BUS_GRANT,
  input wire logic         BUS_UNIT_RST,
  input wire logic         PERIPH_RST,
  input wire csa_pd_t      SLEEP_MODE,
  input wire csa_pd_t      PDOWN_MODE
);
  logic taken;
  logic hi_ok;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // An access is judged only while executing; upper region is fine when privileged
  assign taken = ACC_REQ.valid && CPU_STATE == 3'h3;
  assign hi_ok = STATUS_WORD[30] || ACC_REQ.translated || ACC_REQ.addr[31:26] != 6'h3F;

  a_state_legal: assert property (CPU_STATE <= 3'h4)
    else $error("core state code out of range");
  a_misalign_err: assert property (taken && ((ACC_REQ.size == CSA_SZ_WORD && ACC_REQ.addr[0])
    || (ACC_REQ.size == CSA_SZ_LONG && ACC_REQ.addr[1:0] != 2'h0)) |=> ACC_RSP.done && ACC_RSP.err)
    else $error("misaligned access not refused");
  a_byte_free: assert property (taken && ACC_REQ.size == CSA_SZ_BYTE && hi_ok
    |=> ACC_RSP.done && !ACC_RSP.err)
    else $error("byte access refused");
  a_user_upper: assert property (taken && !hi_ok |=> ACC_RSP.err)
    else $error("user access to upper region allowed");
  a_err_aborts: assert property (ACC_RSP.err |-> CPU_STATE == 3'h1 ##1 CPU_STATE == 3'h3 && FETCH_VALID)
    else $error("address error without exception entry");
  a_entry_bits: assert property (CPU_STATE == 3'h1 |-> STATUS_WORD[30:28] == 3'h7)
    else $error("mode, bank or block bit clear in exception");
  a_quad_pass: assert property (taken && ACC_REQ.size == CSA_SZ_QUAD && ACC_REQ.addr[2:0] == 3'h0 && hi_ok
    |=> ACC_RSP.load_data == $past(ACC_REQ.rdata))
    else $error("quad data altered");
  a_reset_fetch: assert property ($past(CPU_STATE) == 3'h0 && CPU_STATE == 3'h3
    |-> FETCH_VALID && FETCH_PC == CSA_RESET_VEC)
    else $error("wrong fetch target after reset");
  a_grant_busrel: assert property (BUS_GRANT == (CPU_STATE == 3'h2))
    else $error("grant and bus-released state disagree");
  a_pdown_mode: assert property ($rose(CPU_STATE == 3'h4) |-> PDOWN_MODE == $past(SLEEP_MODE))
    else $error("power-down variant not taken from request");
  a_bus_unit_rst: assert property (BUS_UNIT_RST |-> PERIPH_RST)
    else $error("bus unit reset without peripheral reset");
endmodule // csa_check

bind csa_top csa_check u_csa_check (.*);

// ---- csa_pkg.sv ----
package csa_pkg;
  // Core state encoding; the output port carries it as a 3-bit code
  typedef enum logic [2:0] {
    CSA_ST_RESET,
    CSA_ST_EXC,
    CSA_ST_BUSREL,
    CSA_ST_EXEC,
    CSA_ST_PDOWN
  } csa_state_t;

  // Access sizes as issued by the load/store unit
  typedef enum logic [1:0] {
    CSA_SZ_BYTE,
    CSA_SZ_WORD,
    CSA_SZ_LONG,
    CSA_SZ_QUAD
  } csa_size_t;

  // Power-down variants chosen by the sleep request
  typedef enum logic [1:0] {
    CSA_PD_SLEEP,
    CSA_PD_DEEP,
    CSA_PD_STANDBY,
    CSA_PD_NONE
  } csa_pd_t;

  // Data access presented by the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        translated;
    csa_size_t   size;
    logic [31:0] addr;
    logic [31:0] rdata;
  } csa_acc_req_t;

  // Result of the access check, one cycle after the request
  typedef struct packed {
    logic        done;
    logic        err;
    logic        ctrl_hit;
    logic [25:0] ctrl_off;
    logic [31:0] load_data;
  } csa_acc_rsp_t;

  localparam logic [31:0] CSA_RESET_VEC = 32'hA0000000;
  localparam logic [31:0] CSA_VBR_RST   = 32'h00000000;
  localparam logic [31:0] CSA_SR_RST    = 32'h700000F0;
  localparam int          CSA_MD_BIT    = 30;
  localparam int          CSA_RB_BIT    = 29;
  localparam int          CSA_BL_BIT    = 28;
  localparam int          CSA_REG_LSB   = 26;
  localparam logic [5:0]  CSA_LO_REGION = 6'h07;
  localparam logic [5:0]  CSA_HI_REGION = 6'h3F;
  localparam int          CSA_SYNC_LEN  = 3;

  // Register offsets on the slave port (byte addresses)
  localparam logic [7:0]  CSA_OFF_SR    = 8'h00;
  localparam logic [7:0]  CSA_OFF_VBR   = 8'h04;
  localparam logic [7:0]  CSA_OFF_SPC   = 8'h08;
  localparam logic [7:0]  CSA_OFF_SSR   = 8'h0C;
  localparam logic [7:0]  CSA_OFF_SGR   = 8'h10;
  localparam logic [7:0]  CSA_OFF_INFO  = 8'h14;
endpackage

// ---- csa_top.sv ----
`timescale 1ns/1ps
module csa_top
  import csa_pkg::*;
#(
  parameter logic [31:0] ADDR_ERR_OFFSET = 32'h00000100
) (
  input  wire logic         SYS_CLK,
  input  wire logic         RST,
  input  wire logic         RESET_PIN_N,
  input  wire logic         MANUAL_RESET_PIN_N,
  input  wire logic         ENDIAN_SELECT_PIN,
  input  wire logic         BUS_REQ,
  input  wire logic         EXC_REQ,
  input  wire logic [31:0]  EXC_OFFSET,
  input  wire logic [31:0]  CUR_PC,
  input  wire logic [31:0]  CUR_SP,
  input  wire logic         SLEEP_EXEC,
  input  wire csa_pd_t      SLEEP_MODE,
  input  wire logic         WAKE,
  input  wire csa_acc_req_t ACC_REQ,
  output csa_acc_rsp_t      ACC_RSP,
  output logic              FETCH_VALID,
  output logic [31:0]       FETCH_PC,
  output logic [2:0]        CPU_STATE,
  output logic [31:0]       STATUS_WORD,
  output logic              LITTLE_ENDIAN,
  output logic              BUS_GRANT,
  output logic              PERIPH_RST,
  output logic              BUS_UNIT_RST,
  output csa_pd_t           PDOWN_MODE,
  input  wire logic [7:0]   AVS_ADDRESS,
  input  wire logic         AVS_READ,
  input  wire logic         AVS_WRITE,
  input  wire logic [31:0]  AVS_WRITEDATA,
  input  wire logic [3:0]   AVS_BYTEENABLE,
  output logic [31:0]       AVS_READDATA,
  output logic              AVS_WAITREQUEST
);

  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
  logic [CSA_SYNC_LEN-1:0] por_sync_reg;
  logic [CSA_SYNC_LEN-1:0] mrst_sync_reg;
  logic [CSA_SYNC_LEN-1:0] end_sync_reg;
  logic [CSA_SYNC_LEN-1:0] busq_sync_reg;
  logic                    por_n_reg;
  logic                    por_n_next;
  logic                    mrst_n_reg;
  logic                    mrst_n_next;
  logic                    endian_pin_reg;
  logic                    endian_pin_next;
  logic                    busq_reg;
  logic                    busq_next;

  // Filtered values follow only once the last two stages agree
  always_comb begin
    por_n_next      = por_n_reg;
    mrst_n_next     = mrst_n_reg;
    endian_pin_next = endian_pin_reg;
    busq_next       = busq_reg;
    if (por_sync_reg[1] == por_sync_reg[2]) begin
      por_n_next = por_sync_reg[2];
    end
    if (mrst_sync_reg[1] == mrst_sync_reg[2]) begin
      mrst_n_next = mrst_sync_reg[2];
    end
    if (end_sync_reg[1] == end_sync_reg[2]) begin
      endian_pin_next = end_sync_reg[2];
    end
    if (busq_sync_reg[1] == busq_sync_reg[2]) begin
      busq_next = busq_sync_reg[2];
    end
  end

  // Reset pins start out asserted so the core comes up in reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      por_sync_reg   <= '0;
      mrst_sync_reg  <= '0;
      end_sync_reg   <= '0;
      busq_sync_reg  <= '0;
      por_n_reg      <= 1'b0;
      mrst_n_reg     <= 1'b0;
      endian_pin_reg <= 1'b0;
      busq_reg       <= 1'b0;
    end else begin
      por_sync_reg   <= {por_sync_reg[1:0], RESET_PIN_N};
      mrst_sync_reg  <= {mrst_sync_reg[1:0], MANUAL_RESET_PIN_N};
      end_sync_reg   <= {end_sync_reg[1:0], ENDIAN_SELECT_PIN};
      busq_sync_reg  <= {busq_sync_reg[1:0], BUS_REQ};
      por_n_reg      <= por_n_next;
      mrst_n_reg     <= mrst_n_next;
      endian_pin_reg <= endian_pin_next;
      busq_reg       <= busq_next;
    end
  end

  // Core state, context and mode registers
  csa_state_t   state_reg,   state_next;
  logic [31:0]  sr_reg,      sr_next;
  logic [31:0]  vbr_reg,     vbr_next;
  logic [31:0]  spc_reg,     spc_next;
  logic [31:0]  ssr_reg,     ssr_next;
  logic [31:0]  sgr_reg,     sgr_next;
  logic [31:0]  pc_reg,      pc_next;
  logic         fvalid_reg,  fvalid_next;
  logic         le_reg,      le_next;
  logic         prst_reg,    prst_next;
  logic         brst_reg,    brst_next;
  logic         grant_reg,   grant_next;
  csa_pd_t      pd_reg,      pd_next;
  csa_acc_rsp_t rsp_reg,     rsp_next;
  logic         wait_reg,    wait_next;
  logic [31:0]  rdata_reg,   rdata_next;

  // Access check terms, evaluated in the cycle the core presents the access
  logic        acc_live;
  logic        acc_misal;
  logic        acc_user_hi;
  logic        acc_err;
  logic [5:0]  acc_region;
  logic [1:0]  lane;
  logic [7:0]  ld_byte;
  logic [15:0] ld_half;
  logic        bus_ack;
  logic [31:0] wmask;

  assign acc_region = ACC_REQ.addr[31:CSA_REG_LSB];
  assign acc_live   = ACC_REQ.valid && (state_reg == CSA_ST_EXEC);
  // Quad accesses are held to 8-byte alignment as well
  assign acc_misal  = ((ACC_REQ.size == CSA_SZ_WORD) && ACC_REQ.addr[0]) ||
                      ((ACC_REQ.size == CSA_SZ_LONG) && (ACC_REQ.addr[1:0] != 2'h0)) ||
                      ((ACC_REQ.size == CSA_SZ_QUAD) && (ACC_REQ.addr[2:0] != 3'h0));
  // Translated accesses may reach the mirror even from user mode
  assign acc_user_hi = (acc_region == CSA_HI_REGION) && !sr_reg[CSA_MD_BIT] &&
                       !ACC_REQ.translated;
  assign acc_err    = acc_live && (acc_misal || acc_user_hi);
  // Byte lane within the longword: big endian counts from the top
  assign lane       = le_reg ? ACC_REQ.addr[1:0] : ~ACC_REQ.addr[1:0];
  assign ld_byte    = ACC_REQ.rdata[{lane, 3'h0} +: 8];
  assign ld_half    = le_reg ? ACC_REQ.rdata[{ACC_REQ.addr[1], 4'h0} +: 16] :
                               ACC_REQ.rdata[{~ACC_REQ.addr[1], 4'h0} +: 16];
  assign bus_ack    = (AVS_READ || AVS_WRITE) && !wait_reg;
  assign wmask      = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                       {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // State sequencing; reset outranks exceptions, which outrank bus and sleep
  always_comb begin
    state_next  = state_reg;
    sr_next     = sr_reg;
    vbr_next    = vbr_reg;
    spc_next    = spc_reg;
    ssr_next    = ssr_reg;
    sgr_next    = sgr_reg;
    pc_next     = pc_reg;
    fvalid_next = 1'b0;
    le_next     = le_reg;
    prst_next   = !por_n_reg || !mrst_n_reg;
    brst_next   = !por_n_reg;
    grant_next  = grant_reg;
    pd_next     = pd_reg;
    // Software writes land first so any hardware entry below overrides them
    if (AVS_WRITE && bus_ack && (AVS_ADDRESS == CSA_OFF_SR)) begin
      sr_next = (sr_reg & ~wmask) | (AVS_WRITEDATA & wmask);
    end
    if (AVS_WRITE && bus_ack && (AVS_ADDRESS == CSA_OFF_VBR)) begin
      vbr_next = (vbr_reg & ~wmask) | (AVS_WRITEDATA & wmask);
    end
    if (!por_n_reg) begin
      // Power-on reset: everything, bus unit included, and catch byte order
      state_next = CSA_ST_RESET;
      // Take the filtered value as it settles, so a strap that clears the filter
      // together with the reset pin is still caught before reset ends
      le_next    = endian_pin_next;
      sr_next    = CSA_SR_RST;
      vbr_next   = CSA_VBR_RST;
      grant_next = 1'b0;
      pd_next    = CSA_PD_NONE;
    end else if (!mrst_n_reg) begin
      // Manual reset keeps byte order and leaves refresh running
      state_next = CSA_ST_RESET;
      sr_next    = CSA_SR_RST;
      vbr_next   = CSA_VBR_RST;
      grant_next = 1'b0;
      pd_next    = CSA_PD_NONE;
    end else begin
      unique case (state_reg)
        CSA_ST_RESET: begin
          state_next  = CSA_ST_EXEC;
          pc_next     = CSA_RESET_VEC;
          fvalid_next = 1'b1;
        end
        CSA_ST_EXC: begin
          state_next  = CSA_ST_EXEC;
          fvalid_next = 1'b1;
        end
        CSA_ST_EXEC: begin
          if (EXC_REQ || acc_err) begin
            // Context save uses the word before any same-cycle software write
            state_next = CSA_ST_EXC;
            spc_next   = CUR_PC;
            ssr_next   = sr_reg;
            sgr_next   = CUR_SP;
            sr_next[CSA_MD_BIT] = 1'b1;
            sr_next[CSA_RB_BIT] = 1'b1;
            sr_next[CSA_BL_BIT] = 1'b1;
            pc_next    = vbr_reg + (acc_err ? ADDR_ERR_OFFSET : EXC_OFFSET);
          end else if (busq_reg) begin
            state_next = CSA_ST_BUSREL;
            grant_next = 1'b1;
          end else if (SLEEP_EXEC) begin
            state_next = CSA_ST_PDOWN;
            pd_next    = SLEEP_MODE;
          end
        end
        CSA_ST_BUSREL: begin
          if (!busq_reg) begin
            state_next = CSA_ST_EXEC;
            grant_next = 1'b0;
          end
        end
        CSA_ST_PDOWN: begin
          if (WAKE) begin
            state_next = CSA_ST_EXEC;
            pd_next    = CSA_PD_NONE;
          end
        end
      endcase
    end
  end

  // Access result: aborted on error, loads widened by sign extension
  always_comb begin
    rsp_next           = '0;
    rsp_next.done      = acc_live;
    rsp_next.err       = acc_err;
    rsp_next.ctrl_hit  = acc_live && !acc_err &&
                         ((acc_region == CSA_LO_REGION) || (acc_region == CSA_HI_REGION));
    rsp_next.ctrl_off  = ACC_REQ.addr[CSA_REG_LSB-1:0];
    if (acc_live && !acc_err && !ACC_REQ.write) begin
      unique case (ACC_REQ.size)
        CSA_SZ_BYTE: rsp_next.load_data = {{24{ld_byte[7]}}, ld_byte};
        CSA_SZ_WORD: rsp_next.load_data = {{16{ld_half[15]}}, ld_half};
        CSA_SZ_LONG: rsp_next.load_data = ACC_REQ.rdata;
        // Halves of a quad pass as they are, so little endian sees them swapped
        CSA_SZ_QUAD: rsp_next.load_data = ACC_REQ.rdata;
      endcase
    end
  end

  // Slave port: one wait cycle per request, then the answer
  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    if ((AVS_READ || AVS_WRITE) && wait_reg) begin
      wait_next = 1'b0;
      // Unmapped offsets read as zero and ignore writes
      unique case (AVS_ADDRESS)
        CSA_OFF_SR:   rdata_next = sr_reg;
        CSA_OFF_VBR:  rdata_next = vbr_reg;
        CSA_OFF_SPC:  rdata_next = spc_reg;
        CSA_OFF_SSR:  rdata_next = ssr_reg;
        CSA_OFF_SGR:  rdata_next = sgr_reg;
        CSA_OFF_INFO: rdata_next = {25'h0000000, le_reg, grant_reg, pd_reg,
                                   state_reg};
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  // All registers but the pin filters; the synchronous reset gives constants only
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg  <= CSA_ST_RESET;
      sr_reg     <= CSA_SR_RST;
      vbr_reg    <= CSA_VBR_RST;
      spc_reg    <= 32'h00000000;
      ssr_reg    <= 32'h00000000;
      sgr_reg    <= 32'h00000000;
      pc_reg     <= CSA_RESET_VEC;
      fvalid_reg <= 1'b0;
      le_reg     <= 1'b0;
      prst_reg   <= 1'b1;
      brst_reg   <= 1'b1;
      grant_reg  <= 1'b0;
      pd_reg     <= CSA_PD_NONE;
      rsp_reg    <= '0;
      wait_reg   <= 1'b1;
      rdata_reg  <= 32'h00000000;
    end else begin
      state_reg  <= state_next;
      sr_reg     <= sr_next;
      vbr_reg    <= vbr_next;
      spc_reg    <= spc_next;
      ssr_reg    <= ssr_next;
      sgr_reg    <= sgr_next;
      pc_reg     <= pc_next;
      fvalid_reg <= fvalid_next;
      le_reg     <= le_next;
      prst_reg   <= prst_next;
      brst_reg   <= brst_next;
      grant_reg  <= grant_next;
      pd_reg     <= pd_next;
      rsp_reg    <= rsp_next;
      wait_reg   <= wait_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Outputs straight from flops
  assign ACC_RSP         = rsp_reg;
  assign FETCH_VALID     = fvalid_reg;
  assign FETCH_PC        = pc_reg;
  assign CPU_STATE       = state_reg;
  assign STATUS_WORD     = sr_reg;
  assign LITTLE_ENDIAN   = le_reg;
  assign BUS_GRANT       = grant_reg;
  assign PERIPH_RST      = prst_reg;
  assign BUS_UNIT_RST    = brst_reg;
  assign PDOWN_MODE      = pd_reg;
  assign AVS_READDATA    = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;

endmodule // csa_top

// ---- tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the core state and access-check block
module tb;
  import csa_pkg::*;
  logic         SYS_CLK = 1'b0;
  logic         RST = 1'b1;
  logic         RESET_PIN_N = 1'b1;
  logic         MANUAL_RESET_PIN_N = 1'b1;
  logic         ENDIAN_SELECT_PIN = 1'b1;
  logic         BUS_REQ;
  logic         EXC_REQ = 1'b0;
  logic [31:0]  EXC_OFFSET = 32'h0;
  logic [31:0]  CUR_PC = 32'h0;
  logic [31:0]  CUR_SP = 32'h0;
  logic         SLEEP_EXEC = 1'b0;
  csa_pd_t      SLEEP_MODE = CSA_PD_NONE;
  logic         WAKE = 1'b0;
  csa_acc_req_t ACC_REQ = '0;
  csa_acc_rsp_t ACC_RSP;
  logic         FETCH_VALID;
  logic [31:0]  FETCH_PC;
  logic [2:0]   CPU_STATE;
  logic [31:0]  STATUS_WORD;
  logic         LITTLE_ENDIAN;
  logic         BUS_GRANT;
  logic         PERIPH_RST;
  logic         BUS_UNIT_RST;
  csa_pd_t      PDOWN_MODE;
  logic [7:0]   AVS_ADDRESS = 8'h0;
  logic         AVS_READ = 1'b0;
  logic         AVS_WRITE = 1'b0;
  logic [31:0]  AVS_WRITEDATA = 32'h0;
  logic [3:0]   AVS_BYTEENABLE = 4'hF;
  logic [31:0]  AVS_READDATA;
  logic         AVS_WAITREQUEST;
  logic         bus_go = 1'b0;
  logic [31:0]  rq;
  csa_acc_rsp_t last;
  int           n_fail = 0;
  int           n_tests = 0;

  always #20 SYS_CLK = ~SYS_CLK;

  csa_top u_csa_top (.*);
  csa_bus_req_model u_csa_bus_req_model (.clk(SYS_CLK), .go(bus_go), .grant(BUS_GRANT), .req(BUS_REQ));

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait a bounded time for a core state, then compare it
  task automatic wst(input logic [2:0] s);
    int n;
    n = 0;
    while (CPU_STATE !== s && n < 40) begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    chk({29'h0, CPU_STATE}, {29'h0, s});
  endtask

  // One bus cycle; the request holds until waitrequest is seen low at an edge
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic w;
    int n;
    @(posedge SYS_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    n = 0;
    do begin
      #1;
      w = AVS_WAITREQUEST;
      rq = AVS_READDATA;
      @(posedge SYS_CLK);
      n++;
    end while (w && n < 20);
    if (w) n_fail++;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    av(1'b0, a, 32'h0);
    chk(rq, exp);
  endtask

  // One data access; leaves room for a possible exception to finish
  task automatic ca(input csa_size_t sz, input logic [31:0] a, input logic [31:0] d,
                    input logic tr, input logic e, input logic [31:0] ld);
    @(posedge SYS_CLK);
    ACC_REQ <= '{1'b1, 1'b0, tr, sz, a, d};
    @(posedge SYS_CLK);
    ACC_REQ.valid <= 1'b0;
    #1;
    last = ACC_RSP;
    chk({30'h0, last.done, last.err}, {30'h0, 1'b1, e});
    if (!e) chk(last.load_data, ld);
    repeat (3) @(posedge SYS_CLK);
  endtask

  task automatic t_access;
    ca(CSA_SZ_BYTE, 32'h00000001, 32'h00009C00, 1'b0, 1'b0, 32'hFFFFFF9C);
    ca(CSA_SZ_WORD, 32'h00000002, 32'h80010000, 1'b0, 1'b0, 32'hFFFF8001);
    ca(CSA_SZ_WORD, 32'h00000003, 32'h0, 1'b0, 1'b1, 32'h0);
    ca(CSA_SZ_LONG, 32'h00000006, 32'h0, 1'b0, 1'b1, 32'h0);
    ca(CSA_SZ_QUAD, 32'h00000008, 32'h12345678, 1'b0, 1'b0, 32'h12345678);
    ca(CSA_SZ_LONG, 32'h1C000004, 32'h00000055, 1'b1, 1'b0, 32'h00000055);
    chk({5'h0, last.ctrl_hit, last.ctrl_off}, 32'h04000004);
    ca(CSA_SZ_LONG, 32'hFC000004, 32'h00000066, 1'b0, 1'b0, 32'h00000066);
    chk({5'h0, last.ctrl_hit, last.ctrl_off}, 32'h04000004);
  endtask

  // User mode: translated reach allowed, direct reach to upper region refused
  task automatic t_user;
    av(1'b1, CSA_OFF_SR, 32'h000000F0);
    chk({31'h0, STATUS_WORD[30]}, 32'h0);
    ca(CSA_SZ_LONG, 32'hFC000008, 32'h00000011, 1'b1, 1'b0, 32'h00000011);
    ca(CSA_SZ_LONG, 32'hFC000008, 32'h0, 1'b0, 1'b1, 32'h0);
    chk({29'h0, STATUS_WORD[30:28]}, 32'h7);
    rd(8'hF0, 32'h0);
  endtask

  task automatic t_exc;
    av(1'b1, CSA_OFF_VBR, 32'h8C000000);
    av(1'b1, CSA_OFF_SR, 32'h400000F0);
    @(posedge SYS_CLK);
    CUR_PC <= 32'h8C001234;
    CUR_SP <= 32'h8C00FFF0;
    EXC_OFFSET <= 32'h00000600;
    EXC_REQ <= 1'b1;
    @(posedge SYS_CLK);
    EXC_REQ <= 1'b0;
    #1;
    chk({29'h0, CPU_STATE}, 32'h1);
    chk(FETCH_PC, 32'h8C000600);
    chk({29'h0, STATUS_WORD[30:28]}, 32'h7);
    rd(CSA_OFF_SPC, 32'h8C001234);
    rd(CSA_OFF_SSR, 32'h400000F0);
    rd(CSA_OFF_SGR, 32'h8C00FFF0);
  endtask

  // Every power-down variant, each left again by a wake-up
  task automatic t_sleep;
    for (int m = 0; m < 3; m++) begin
      @(posedge SYS_CLK);
      SLEEP_MODE <= csa_pd_t'(m);
      SLEEP_EXEC <= 1'b1;
      @(posedge SYS_CLK);
      SLEEP_EXEC <= 1'b0;
      #1;
      chk({29'h0, CPU_STATE}, 32'h4);
      chk({30'h0, PDOWN_MODE}, m);
      @(posedge SYS_CLK);
      WAKE <= 1'b1;
      @(posedge SYS_CLK);
      WAKE <= 1'b0;
      #1;
      chk({29'h0, CPU_STATE}, 32'h3);
    end
  endtask

  task automatic t_bus;
    @(posedge SYS_CLK);
    bus_go <= 1'b1;
    @(posedge SYS_CLK);
    bus_go <= 1'b0;
    wst(3'h2);
    chk({31'h0, BUS_GRANT}, 32'h1);
    wst(3'h3);
    chk({31'h0, BUS_GRANT}, 32'h0);
  endtask

  // Manual reset spares byte order and bus unit; power-on reset relatches both
  task automatic t_resets;
    @(posedge SYS_CLK);
    MANUAL_RESET_PIN_N <= 1'b0;
    ENDIAN_SELECT_PIN <= 1'b0;
    wst(3'h0);
    chk({30'h0, PERIPH_RST, BUS_UNIT_RST}, 32'h2);
    @(posedge SYS_CLK);
    MANUAL_RESET_PIN_N <= 1'b1;
    wst(3'h3);
    chk({31'h0, LITTLE_ENDIAN}, 32'h1);
    @(posedge SYS_CLK);
    RESET_PIN_N <= 1'b0;
    wst(3'h0);
    chk({30'h0, PERIPH_RST, BUS_UNIT_RST}, 32'h3);
    @(posedge SYS_CLK);
    RESET_PIN_N <= 1'b1;
    wst(3'h3);
    chk(FETCH_PC, CSA_RESET_VEC);
    chk({31'h0, LITTLE_ENDIAN}, 32'h0);
    rd(CSA_OFF_VBR, CSA_VBR_RST);
    ca(CSA_SZ_BYTE, 32'h0, 32'h80000000, 1'b0, 1'b0, 32'hFFFFFF80);
    // Info word: big endian, no grant, no power-down variant, executing
    rd(CSA_OFF_INFO, 32'h0000001B);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    wst(3'h3);
    chk(FETCH_PC, CSA_RESET_VEC);
    chk({29'h0, STATUS_WORD[30:28]}, 32'h7);
    chk({31'h0, LITTLE_ENDIAN}, 32'h1);
    rd(CSA_OFF_VBR, CSA_VBR_RST);
    t_access();
    t_user();
    t_exc();
    t_sleep();
    t_bus();
    t_resets();
    end_of_test();
  end

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    n_fail++;
    end_of_test();
  end
endmodule // tb
